// >>> logic/host_port_pkg.sv
package host_port_pkg;

    localparam int ADDR_W    = 7;
    localparam int DATA_W    = 16;
    localparam int WORD_W    = 32;
    localparam int IDX_W     = 6;
    localparam int BUF_DEPTH = 2;
    localparam int CNT_W     = 2;

    // address bits still decoded while the fifo select input is high
    localparam logic [ADDR_W-1:0] FIFO_ADDR_MASK = 7'h03;
    localparam logic              HALF_LOW       = 1'b0;
    localparam logic              HALF_HIGH      = 1'b1;
    localparam logic [CNT_W-1:0]  CNT_ZERO       = 2'h0;
    localparam logic [CNT_W-1:0]  CNT_ONE        = 2'h1;
    localparam logic [CNT_W-1:0]  CNT_FULL       = 2'h2;

    typedef enum logic [1:0] {
        RD_IDLE,
        RD_FETCH,
        RD_DRIVE
    } rd_phase_e;

    typedef struct packed {
        logic              chip_select_n;
        logic              read_strobe_n;
        logic              write_strobe_n;
        logic              fifo_sel;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } host_bus_s;

    typedef struct packed {
        logic             is_fifo;
        logic [IDX_W-1:0] idx;
        logic [WORD_W-1:0] data;
    } word_s;

    typedef struct packed {
        logic source_enable;
        logic active_high;
        logic open_drain;
    } irq_cfg_s;

    function automatic logic [ADDR_W-1:0] eff_addr(input logic              fifo_sel,
                                                   input logic [ADDR_W-1:0] addr);
        eff_addr = fifo_sel ? (addr & FIFO_ADDR_MASK) : addr;
    endfunction : eff_addr

endpackage : host_port_pkg

// >>> logic/word_buffer.sv
`timescale 1ns/1ps
module word_buffer (
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire logic                in_valid,
    output logic                     in_ready,
    input  wire host_port_pkg::word_s in_word,
    output logic                     out_valid,
    input  wire logic                out_ready,
    output host_port_pkg::word_s     out_word
);

    typedef struct packed {
        host_port_pkg::word_s [host_port_pkg::BUF_DEPTH-1:0] mem;
        logic                                                wr_ptr;
        logic                                                rd_ptr;
        logic [host_port_pkg::CNT_W-1:0]                     count;
    } buf_state_s;

    buf_state_s st_ff;
    buf_state_s nxt_st;
    logic       push;
    logic       pop;

    assign in_ready  = (st_ff.count != host_port_pkg::CNT_FULL);
    assign out_valid = (st_ff.count != host_port_pkg::CNT_ZERO);
    assign out_word  = st_ff.mem[st_ff.rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wr_ptr] = in_word;
            nxt_st.wr_ptr            = ~st_ff.wr_ptr;
        end
        if (pop) begin
            nxt_st.rd_ptr = ~st_ff.rd_ptr;
        end
        if (push && !pop) begin
            nxt_st.count = st_ff.count + host_port_pkg::CNT_ONE;
        end else if (pop && !push) begin
            nxt_st.count = st_ff.count - host_port_pkg::CNT_ONE;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule : word_buffer

// >>> logic/host_bus_port.sv
`timescale 1ns/1ps
// Summary of operation
// (R1) decode seven halfword address bits, 16-bit data
// (R2) drive data only during qualified read
// (R3) host writes with strobe low, data valid
// (R4) strobes count only with chip select low
// (R5) write with chip select wakes from low power
// (R6) interrupt polarity, source and driver programmable
// (R7) fifo select routes accesses to data fifos
// (R8) fifo select ignores upper address bits
// (R9) writes ignored until first read after reset/wake
// (R10) host wakes via endian test register write
// (R11) sram-like programmed reads and writes only
// (R12) internal word paths are 32 bits wide
// (R13) pair two halfword accesses into one word
module host_bus_port (
    input  wire logic                                 clock,
    input  wire logic                                 rst,
    input  wire host_port_pkg::host_bus_s             host_in,
    output logic [host_port_pkg::DATA_W-1:0]          host_data_out,
    output logic                                      host_data_oe_n,
    input  wire host_port_pkg::irq_cfg_s              irq_cfg,
    input  wire logic                                 irq_event,
    output logic                                      irq_out,
    output logic                                      irq_oe_n,
    input  wire logic                                 low_power,
    output logic                                      wake,
    output logic                                      rd_req,
    output logic                                      rd_is_fifo,
    output logic [host_port_pkg::IDX_W-1:0]           rd_idx,
    input  wire logic [host_port_pkg::WORD_W-1:0]     rd_data,
    output logic                                      wr_valid,
    input  wire logic                                 wr_ready,
    output host_port_pkg::word_s                      wr_word
);

    typedef struct packed {
        logic                               rd_prev;
        logic                               wr_prev;
        logic                               armed;
        logic [host_port_pkg::ADDR_W-1:0]   wr_addr;
        logic                               wr_fifo;
        logic [host_port_pkg::DATA_W-1:0]   wr_data;
        logic                               lo_valid;
        logic                               lo_fifo;
        logic [host_port_pkg::IDX_W-1:0]    lo_idx;
        logic [host_port_pkg::DATA_W-1:0]   lo_data;
        host_port_pkg::word_s               pend;
        logic                               pend_valid;
        host_port_pkg::rd_phase_e           rd_phase;
        logic                               rd_half;
        logic                               hi_valid;
        logic                               hi_fifo;
        logic [host_port_pkg::IDX_W-1:0]    hi_idx;
        logic [host_port_pkg::DATA_W-1:0]   hi_data;
        logic [host_port_pkg::DATA_W-1:0]   data_out;
        logic                               wake;
        logic                               rd_req;
        logic                               rd_fifo;
        logic [host_port_pkg::IDX_W-1:0]    rd_idx;
        logic                               irq_level;
        logic                               irq_oe_n;
    } port_state_s;

    port_state_s                      st_ff;
    port_state_s                      nxt_st;
    logic                             q_rd;
    logic                             q_wr;
    logic [host_port_pkg::ADDR_W-1:0] addr_e;
    logic                             buf_ready;
    logic                             irq_active;

    ////////////////////////////////////////////////////////////////////////////////
    // qualified strobes and decoded address

    assign q_rd   = !host_in.chip_select_n && !host_in.read_strobe_n;   // see (R4)
    assign q_wr   = !host_in.chip_select_n && !host_in.write_strobe_n;  // see (R4)
    assign addr_e = host_port_pkg::eff_addr(host_in.fifo_sel, host_in.addr); // see (R8)

    assign irq_active = irq_event && irq_cfg.source_enable;             // see (R6)

    assign host_data_out  = st_ff.data_out;
    assign host_data_oe_n = !q_rd;                                      // see (R2)
    assign irq_out        = st_ff.irq_level;
    assign irq_oe_n       = st_ff.irq_oe_n;
    assign wake           = st_ff.wake;
    assign rd_req         = st_ff.rd_req;
    assign rd_is_fifo     = st_ff.rd_fifo;
    assign rd_idx         = st_ff.rd_idx;

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        nxt_st         = st_ff;
        nxt_st.rd_prev = q_rd;
        nxt_st.wr_prev = q_wr;
        nxt_st.wake    = 1'b0;
        nxt_st.rd_req  = 1'b0;

        // interrupt pin: level active per polarity, open drain only pulls low
        nxt_st.irq_level = irq_active ~^ irq_cfg.active_high;           // see (R6)
        nxt_st.irq_oe_n  = irq_cfg.open_drain ? nxt_st.irq_level : 1'b0; // see (R6)
        if (irq_cfg.open_drain) begin
            nxt_st.irq_level = 1'b0;
        end

        // write side: sample while asserted, act on trailing edge
        if (q_wr) begin
            nxt_st.wr_addr = addr_e;                                    // see (R1)
            nxt_st.wr_fifo = host_in.fifo_sel;                          // see (R7)
            nxt_st.wr_data = host_in.data;                              // see (R3)
        end
        if (q_wr && !st_ff.wr_prev && low_power) begin
            nxt_st.wake  = 1'b1;                                        // see (R5)
            nxt_st.armed = 1'b0;                                        // see (R9)
        end
        if (st_ff.pend_valid && buf_ready) begin
            nxt_st.pend_valid = 1'b0;
        end
        if (!q_wr && st_ff.wr_prev && st_ff.armed) begin                // see (R9)
            if (st_ff.wr_addr[0] == host_port_pkg::HALF_LOW) begin
                nxt_st.lo_valid = 1'b1;                                 // see (R13)
                nxt_st.lo_fifo  = st_ff.wr_fifo;
                nxt_st.lo_idx   = st_ff.wr_addr[host_port_pkg::ADDR_W-1:1];
                nxt_st.lo_data  = st_ff.wr_data;
            end else begin
                nxt_st.lo_valid = 1'b0;
                if (st_ff.lo_valid && st_ff.lo_fifo == st_ff.wr_fifo &&
                    st_ff.lo_idx == st_ff.wr_addr[host_port_pkg::ADDR_W-1:1] &&
                    !nxt_st.pend_valid) begin
                    nxt_st.pend_valid   = 1'b1;                         // see (R13)
                    nxt_st.pend.is_fifo = st_ff.wr_fifo;                // see (R7)
                    nxt_st.pend.idx     = st_ff.lo_idx;
                    nxt_st.pend.data    = {st_ff.wr_data, st_ff.lo_data}; // see (R12)
                end
            end
        end

        // read side
        case (st_ff.rd_phase)
            host_port_pkg::RD_IDLE: begin
                if (q_rd && !st_ff.rd_prev) begin
                    nxt_st.armed   = 1'b1;                              // see (R9)
                    nxt_st.rd_half = addr_e[0];
                    if (addr_e[0] == host_port_pkg::HALF_HIGH && st_ff.hi_valid &&
                        st_ff.hi_fifo == host_in.fifo_sel &&
                        st_ff.hi_idx == addr_e[host_port_pkg::ADDR_W-1:1]) begin
                        nxt_st.data_out = st_ff.hi_data;                // see (R13)
                        nxt_st.hi_valid = 1'b0;
                        nxt_st.rd_phase = host_port_pkg::RD_DRIVE;
                    end else begin
                        nxt_st.rd_req   = 1'b1;                         // see (R11)
                        nxt_st.rd_fifo  = host_in.fifo_sel;             // see (R7)
                        nxt_st.rd_idx   = addr_e[host_port_pkg::ADDR_W-1:1]; // see (R1)
                        nxt_st.rd_phase = host_port_pkg::RD_FETCH;
                    end
                end
            end
            host_port_pkg::RD_FETCH: begin
                if (st_ff.rd_half == host_port_pkg::HALF_LOW) begin
                    nxt_st.data_out = rd_data[host_port_pkg::DATA_W-1:0];      // see (R12)
                    nxt_st.hi_valid = 1'b1;                                     // see (R13)
                    nxt_st.hi_fifo  = st_ff.rd_fifo;
                    nxt_st.hi_idx   = st_ff.rd_idx;
                    nxt_st.hi_data  = rd_data[host_port_pkg::WORD_W-1:host_port_pkg::DATA_W];
                end else begin
                    nxt_st.data_out = rd_data[host_port_pkg::WORD_W-1:host_port_pkg::DATA_W];
                    nxt_st.hi_valid = 1'b0;
                end
                nxt_st.rd_phase = q_rd ? host_port_pkg::RD_DRIVE : host_port_pkg::RD_IDLE;
            end
            host_port_pkg::RD_DRIVE: begin
                if (!q_rd) begin
                    nxt_st.rd_phase = host_port_pkg::RD_IDLE;
                end
            end
            default: begin
                nxt_st.rd_phase = host_port_pkg::RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_ff          <= '0;
            st_ff.irq_oe_n <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // two-entry buffer toward the core

    word_buffer u_word_buffer (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (st_ff.pend_valid),
        .in_ready  (buf_ready),
        .in_word   (st_ff.pend),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_word  (wr_word)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    chk_fifo_addr_mask: assert property (rd_req && rd_is_fifo |-> rd_idx[5:1] == '0) // see (R8)
        else $error("fifo read kept upper address bits");
    chk_read_drive_qual: assert property // see (R2)
        (!host_data_oe_n == (!host_in.chip_select_n && !host_in.read_strobe_n))
        else $error("data drive does not follow qualified read");
    chk_read_req_qual: assert property (rd_req |-> $past(q_rd) && !$past(st_ff.rd_prev)) // see (R4)
        else $error("core read without qualified strobe");
    chk_wake_on_write: assert property ($rose(q_wr) && low_power |=> wake ##1 !wake) // see (R5)
        else $error("wake pulse missing or too long");
    chk_wake_cause: assert property (wake |-> $past(q_wr) && $past(low_power)) // see (R5)
        else $error("wake without qualified write");
    chk_irq_level: assert property (!$past(rst) // see (R6)
        && irq_cfg.open_drain == 1'b0 && $stable(irq_cfg)
        |=> !irq_oe_n && irq_out == ($past(irq_active) ~^ $past(irq_cfg.active_high)))
        else $error("push pull interrupt level wrong");
    chk_irq_open_drain: assert property (!$past(rst) // see (R6)
        && irq_cfg.open_drain && $stable(irq_cfg)
        |=> !irq_out && irq_oe_n == ($past(irq_active) ~^ $past(irq_cfg.active_high)))
        else $error("open drain interrupt drive wrong");
    chk_write_needs_read: assert property ($rose(st_ff.pend_valid) |-> $past(st_ff.armed)) // see (R9)
        else $error("write committed before first read");
    chk_word_pairing: assert property ($rose(st_ff.pend_valid) // see (R13)
        |-> st_ff.pend.data[15:0] == $past(st_ff.lo_data)
            && st_ff.pend.idx == $past(st_ff.lo_idx))
        else $error("word not built from matching halves");
    chk_fetch_half: assert property (rd_req // see (R12)
        |=> host_data_out == ($past(st_ff.rd_half)
            ? $past(rd_data[31:16]) : $past(rd_data[15:0])))
        else $error("wrong half of fetched word");
    chk_pend_hold: assert property (st_ff.pend_valid && !buf_ready // see (R13)
        |=> st_ff.pend_valid && $stable(st_ff.pend))
        else $error("pending word lost under stall");

    cov_wake:      cover property ($rose(q_wr) && low_power ##1 wake);
    cov_pair:      cover property ($rose(st_ff.pend_valid));
    cov_hi_latch:  cover property (q_rd && st_ff.rd_phase == host_port_pkg::RD_IDLE
                                   && st_ff.hi_valid && addr_e[0]);
    cov_buf_full:  cover property (st_ff.pend_valid && !buf_ready);

endmodule : host_bus_port

// >>> test/core_model.sv
`timescale 1ns/1ps
module core_model (
    input  wire logic                             clock,
    input  wire logic                             rst,
    input  wire logic                             stall,
    input  wire logic                             rd_req,
    input  wire logic                             rd_is_fifo,
    input  wire logic [host_port_pkg::IDX_W-1:0]  rd_idx,
    output logic [host_port_pkg::WORD_W-1:0]      rd_data,
    output logic                                  wr_ready
);
    logic [15:0] cyc_ff;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cyc_ff   <= 16'h0000;
            wr_ready <= 1'b0;
        end else begin
            cyc_ff   <= cyc_ff + 16'h0001;
            wr_ready <= !stall;
        end
    end
    // word only while asked for, a moving pattern otherwise
    assign rd_data = rd_req ? {2'h2, rd_is_fifo, rd_idx, 7'h15, ~rd_is_fifo, ~rd_idx, 9'h0a5}
                            : {cyc_ff, ~cyc_ff};
endmodule : core_model

// >>> test/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic                     clock = 0, rst = 1, stall, low_power, irq_event;
    logic                     cs_n, rd_n, wr_n, fsel, drv_on, armed, lo_v, act;
    logic [6:0]               addr, lo_key, exp_rd, ra;
    logic [15:0]              drv, lo_d, bus, dout, rh, rl;
    host_port_pkg::host_bus_s hin;
    host_port_pkg::irq_cfg_s  cfg;
    host_port_pkg::word_s     wr_word, exp_q[$];
    logic                     oe_n, irq_out, irq_oe_n, wake, rd_req, rd_is_fifo, wr_valid, wr_ready;
    logic [5:0]               rd_idx;
    logic [31:0]              rd_data;
    integer                   num_errors = 0, compares = 0, seed = 32'h383c, cycles = 0;
    integer                   wakes = 0, reqs = 0, n;
    // released bus shows the inverse of the last value
    assign bus = !oe_n ? dout : drv_on ? drv : ~dout;
    assign hin = {cs_n, rd_n, wr_n, fsel, addr, bus};
    host_bus_port uut (.clock(clock), .rst(rst), .host_in(hin), .host_data_out(dout),
        .host_data_oe_n(oe_n), .irq_cfg(cfg), .irq_event(irq_event), .irq_out(irq_out),
        .irq_oe_n(irq_oe_n), .low_power(low_power), .wake(wake), .rd_req(rd_req),
        .rd_is_fifo(rd_is_fifo), .rd_idx(rd_idx), .rd_data(rd_data), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_word(wr_word));
    core_model core (.clock(clock), .rst(rst), .stall(stall), .rd_req(rd_req),
        .rd_is_fifo(rd_is_fifo), .rd_idx(rd_idx), .rd_data(rd_data), .wr_ready(wr_ready));
    initial begin
        forever #50 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////////////////
    task wrap_up;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up
    task check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task rd(input logic f, input logic [6:0] a);
        logic [6:0]  e;
        logic [31:0] w;
        e = f ? (a & 7'h03) : a;
        w = {2'h2, f, e[6:1], 7'h15, ~f, ~e[6:1], 9'h0a5};
        exp_rd = {f, e[6:1]};
        armed = 1;
        @(posedge clock);
        {cs_n, rd_n, fsel, addr} <= {2'h0, f, a};
        repeat (4) @(posedge clock);
        @(negedge clock);
        check(dout, e[0] ? w[31:16] : w[15:0]);
        check(oe_n, 1'b0);
        @(posedge clock);
        {cs_n, rd_n} <= 2'h3;
        @(negedge clock);
        check(oe_n, 1'b1);
    endtask : rd
    task wr(input logic f, input logic [6:0] a, input logic [15:0] d);
        logic [6:0] e;
        e = f ? (a & 7'h03) : a;
        if (low_power) armed = 0;
        else if (armed && !e[0]) {lo_v, lo_key, lo_d} = {1'b1, f, e[6:1], d};
        else if (armed) begin
            if (lo_v && lo_key === {f, e[6:1]} && (!stall || exp_q.size() < 3))
                exp_q.push_back({f, e[6:1], d, lo_d});
            lo_v = 0;
        end
        @(posedge clock);
        {cs_n, wr_n, fsel, addr, drv, drv_on} <= {2'h0, f, a, d, 1'b1};
        @(posedge clock);
        {cs_n, wr_n} <= 2'h3;
        @(posedge clock);
        drv_on <= 0;
    endtask : wr
    task wp(input logic f, input logic [6:0] a, input logic [15:0] h, input logic [15:0] l);
        wr(f, a & 7'h7e, l);
        wr(f, a | 7'h01, h);
    endtask : wp
    task drain(input string name);
        for (int k = 0; k < 30 && exp_q.size() > 0; k++) @(posedge clock);
        repeat (6) @(posedge clock);
        check(exp_q.size(), 0);
        $display("test %0s done", name);
    endtask : drain
    ////////////////////////////////////////////////////////////////////////////////////////
    always @(negedge clock) begin
        if (!rst && rd_req === 1'b1) begin
            reqs++;
            check({rd_is_fifo, rd_idx}, exp_rd);
        end
        if (!rst && wake === 1'b1) wakes++;
        if (!rst && wr_valid === 1'b1 && wr_ready === 1'b1) begin
            if (exp_q.size() == 0) check(1'b1, 1'b0);
            else check(wr_word, exp_q.pop_front());
        end
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 6000) begin
            num_errors++;
            wrap_up();
        end
    end
    initial begin
        {cs_n, rd_n, wr_n, fsel, addr, drv, drv_on} = {4'he, 7'h00, 16'h0000, 1'b0};
        {stall, low_power, irq_event, cfg, armed, lo_v} = 8'h00;
        repeat (6) @(posedge clock);
        rst <= 0;
        wp(0, 7'h10, 16'h1234, 16'h5678);
        drain("arming");
        n = reqs;
        rd(0, 7'h24);
        rd(0, 7'h25);
        check(reqs - n, 1);
        rd(1, 7'h7e);
        drain("read pair");
        for (int i = 0; i < 8; i++) begin
            ra = $random(seed);
            {rh, rl} = $random(seed);
            wp(i[0], ra, rh, rl);
        end
        wr(0, 7'h41, 16'h0bad);
        drain("random writes");
        stall <= 1;
        for (int i = 0; i < 4; i++) wp(0, 7'h08 + 7'(i * 2), 16'h0a00 + 16'(i), 16'h0b00);
        stall <= 0;
        drain("stall");
        @(posedge clock);
        rd_n <= 0;
        repeat (3) @(posedge clock);
        @(negedge clock);
        check(oe_n, 1'b1);
        rd_n <= 1;
        for (int i = 0; i < 2; i++) begin
            @(posedge clock);
            {wr_n, addr} <= {1'b0, 7'(7'h30 + i)};
            @(posedge clock);
            wr_n <= 1;
        end
        drain("select");
        low_power <= 1;
        @(posedge clock);
        n = wakes;
        wr(0, 7'h32, 16'h0001);
        low_power <= 0;
        repeat (4) @(posedge clock);
        check(wakes - n, 1);
        wp(0, 7'h12, 16'h2222, 16'h3333);
        rd(0, 7'h06);
        wp(0, 7'h14, 16'h4444, 16'h5555);
        drain("wake");
        for (int i = 0; i < 16; i++) begin
            @(posedge clock);
            {cfg, irq_event} <= 4'(i);
            repeat (3) @(posedge clock);
            @(negedge clock);
            act = i[0] & i[3];
            check(irq_oe_n ? 1'b1 : irq_out, i[2] ? act : !act);
            if (!i[1]) check(irq_oe_n, 1'b0);
        end
        $display("test irq done");
        wrap_up();
    end
endmodule : testbench
